/* File: spcs_pkg.sv */
// Package of constants, register map and carrier types for the serial port channel select block.
package spcs_pkg;

  // ==========================================================================
  // Channel organisation
  localparam int unsigned SPCS_PARTS = 8;
  localparam int unsigned SPCS_CH_PER_PART = 16;
  localparam logic [7:0] SPCS_LIMIT_NARROW = 8'h20;
  localparam logic [7:0] SPCS_LIMIT_WIDE = 8'h80;
  localparam logic [7:0] SPCS_LIMIT_HALT = 8'h01;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] SPCS_OFS_RX_ENA = 8'h00;
  localparam logic [7:0] SPCS_OFS_TX_ENA = 8'h20;
  localparam logic [7:0] SPCS_OFS_CTRL_ONE = 8'h40;
  localparam logic [7:0] SPCS_OFS_CTRL_TWO = 8'h44;
  localparam logic [7:0] SPCS_OFS_CONFIG = 8'h48;
  localparam logic [7:0] SPCS_OFS_RX_DATA = 8'h4c;
  localparam logic [7:0] SPCS_OFS_RX_STAT = 8'h50;
  localparam logic [7:0] SPCS_OFS_TX_DATA = 8'h54;
  localparam logic [7:0] SPCS_OFS_TX_STAT = 8'h58;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned SPCS_WIDE_BIT = 9;
  localparam int unsigned SPCS_CFG_HALT_BIT = 3;
  localparam int unsigned SPCS_CFG_MASTER_BIT = 4;
  localparam int unsigned SPCS_STAT_FULL_BIT = 8;
  localparam int unsigned SPCS_STAT_OVR_BIT = 9;
  localparam logic [15:0] SPCS_ENA_RST = 16'h0000;
  localparam logic [2:0] SPCS_WL_RST = 3'h0;

  // ==========================================================================
  // Carrier types
  typedef logic [SPCS_PARTS-1:0][SPCS_CH_PER_PART-1:0] spcs_ena_t;

  typedef struct packed {
    spcs_ena_t rx_ena;
    spcs_ena_t tx_ena;
    logic rx_wide_channel_mode;
    logic tx_wide_channel_mode;
    logic [2:0] wl_code;
    logic clock_halt_mode;
    logic spi_master;
  } spcs_cfg_s;

  typedef struct packed {
    logic frame_sync;
    logic data;
  } spcs_link_in_s;

  typedef struct packed {
    logic data;
    logic data_oe;
    logic frame_sync;
    logic frame_sync_oe;
  } spcs_link_out_s;

  // Word length code to bits; codes above 5 fall back to the shortest word.
  function automatic logic [5:0] spcs_word_bits(input logic [2:0] code);
    case (code)
      3'h1: spcs_word_bits = 6'h0c;
      3'h2: spcs_word_bits = 6'h10;
      3'h3: spcs_word_bits = 6'h14;
      3'h4: spcs_word_bits = 6'h18;
      3'h5: spcs_word_bits = 6'h20;
      default: spcs_word_bits = 6'h08;
    endcase
  endfunction

endpackage

/* File: spcs_top.sv */
// Serial port channel select block: AHB-Lite register slave and link-side channel engine.
`timescale 1ns/1ps
module spcs_top
  import spcs_pkg::*;
(
  // Bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial link
  input wire logic link_clk,
  input wire spcs_link_in_s link_in,
  output spcs_link_out_s link_out
);

  // ==========================================================================
  // State types
  typedef struct packed {
    spcs_cfg_s cfg;
    logic [31:0] tx_word;
    logic tx_tgl;
    logic [1:0] ack_sync;
    logic [2:0] rxt_sync;
    logic [31:0] rx_data;
    logic [6:0] rx_chan;
    logic rx_full;
    logic rx_ovr;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic ready;
    logic [31:0] rdata;
  } spcs_hst_s;

  typedef struct packed {
    spcs_cfg_s cfg_meta;
    spcs_cfg_s cfg;
    logic [1:0] txt_sync;
    logic tx_seen;
    logic [31:0] tx_buf;
    logic tx_full;
    logic active;
    logic [4:0] bit_idx;
    logic [6:0] chan;
    logic [31:0] rx_sh;
    logic [31:0] rx_hold;
    logic [6:0] rx_chan;
    logic rx_tgl;
    logic [31:0] tx_sh;
    spcs_link_out_s pins;
  } spcs_lnk_s;

  spcs_hst_s h;
  spcs_hst_s next_h;
  spcs_lnk_s l;
  spcs_lnk_s next_l;
  logic [1:0] lrst_sync;
  logic lrst_n;
  logic rx_evt;
  logic tx_busy;
  logic live;
  logic start;
  logic last;
  logic rx_en;
  logic tx_en;
  logic wide;
  logic [6:0] cur_chan;
  logic [4:0] cur_bit;
  logic [5:0] wbits;
  logic [7:0] limit;

  // ==========================================================================
  // Bus side
  // Outputs come straight from state; the slave never signals an error.
  assign hreadyout = h.ready;
  assign hrdata = h.rdata;
  assign hresp = 1'b0;
  assign rx_evt = h.rxt_sync[2] ^ h.rxt_sync[1];
  assign tx_busy = h.tx_tgl ^ h.ack_sync[1];

  // Writes land in their data phase; reads take one wait state so that a write
  // just before them is already visible.
  always_comb
  begin
    next_h = h;
    next_h.ack_sync = {h.ack_sync[0], l.tx_seen};
    next_h.rxt_sync = {h.rxt_sync[1:0], l.rx_tgl};
    if (h.wr_pend)
    begin
      next_h.wr_pend = 1'b0;
      if (h.addr[7:5] == SPCS_OFS_RX_ENA[7:5])
        next_h.cfg.rx_ena[h.addr[4:2]] = hwdata[15:0];
      else if (h.addr[7:5] == SPCS_OFS_TX_ENA[7:5])
        next_h.cfg.tx_ena[h.addr[4:2]] = hwdata[15:0];
      else
        case (h.addr)
          SPCS_OFS_CTRL_ONE: next_h.cfg.rx_wide_channel_mode = hwdata[SPCS_WIDE_BIT];
          SPCS_OFS_CTRL_TWO: next_h.cfg.tx_wide_channel_mode = hwdata[SPCS_WIDE_BIT];
          SPCS_OFS_CONFIG:
          begin
            next_h.cfg.wl_code = hwdata[2:0];
            next_h.cfg.clock_halt_mode = hwdata[SPCS_CFG_HALT_BIT];
            next_h.cfg.spi_master = hwdata[SPCS_CFG_MASTER_BIT];
          end
          SPCS_OFS_RX_STAT:
            if (hwdata[SPCS_STAT_OVR_BIT])
              next_h.rx_ovr = 1'b0;
          SPCS_OFS_TX_DATA:
            // A word written while the previous one is still in flight is dropped.
            if (!tx_busy)
            begin
              next_h.tx_word = hwdata;
              next_h.tx_tgl = ~h.tx_tgl;
            end
          default: next_h.ready = 1'b1;
        endcase
    end
    if (h.rd_pend)
    begin
      next_h.rd_pend = 1'b0;
      next_h.ready = 1'b1;
      next_h.rdata = 32'h0000_0000;
      if (h.addr[7:5] == SPCS_OFS_RX_ENA[7:5])
        next_h.rdata[15:0] = h.cfg.rx_ena[h.addr[4:2]];
      else if (h.addr[7:5] == SPCS_OFS_TX_ENA[7:5])
        next_h.rdata[15:0] = h.cfg.tx_ena[h.addr[4:2]];
      else
        case (h.addr)
          SPCS_OFS_CTRL_ONE: next_h.rdata[SPCS_WIDE_BIT] = h.cfg.rx_wide_channel_mode;
          SPCS_OFS_CTRL_TWO: next_h.rdata[SPCS_WIDE_BIT] = h.cfg.tx_wide_channel_mode;
          SPCS_OFS_CONFIG:
          begin
            next_h.rdata[2:0] = h.cfg.wl_code;
            next_h.rdata[SPCS_CFG_HALT_BIT] = h.cfg.clock_halt_mode;
            next_h.rdata[SPCS_CFG_MASTER_BIT] = h.cfg.spi_master;
          end
          SPCS_OFS_RX_DATA:
          begin
            next_h.rdata = h.rx_data;
            next_h.rx_full = 1'b0;
          end
          SPCS_OFS_RX_STAT:
          begin
            next_h.rdata[6:0] = h.rx_chan;
            next_h.rdata[SPCS_STAT_FULL_BIT] = h.rx_full;
            next_h.rdata[SPCS_STAT_OVR_BIT] = h.rx_ovr;
          end
          SPCS_OFS_TX_DATA: next_h.rdata = h.tx_word;
          SPCS_OFS_TX_STAT: next_h.rdata[0] = tx_busy;
          default: next_h.rdata = 32'h0000_0000;
        endcase
    end
    // The link holds its word for at least eight bit times, far longer than the
    // toggle takes to cross, so the held word is stable when it is copied.
    // A new word beats a clear in the same cycle.
    if (rx_evt)
    begin
      next_h.rx_data = l.rx_hold;
      next_h.rx_chan = l.rx_chan;
      next_h.rx_ovr = next_h.rx_ovr | (h.rx_full & next_h.rx_full);
      next_h.rx_full = 1'b1;
    end
    if (hsel && htrans[1] && hready)
    begin
      next_h.addr = haddr[7:0];
      next_h.wr_pend = hwrite;
      next_h.rd_pend = ~hwrite;
      next_h.ready = hwrite;
    end
  end

  // Bus side state register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      h <= '0;
      h.cfg.wl_code <= SPCS_WL_RST;
      h.ready <= 1'b1;
    end
    else
      h <= next_h;
  end

  // ==========================================================================
  // Link side
  // Reset reaches the link domain through two flip-flops; it is released only
  // once the link clock runs.
  always_ff @(posedge link_clk or negedge hresetn)
  begin
    if (!hresetn)
      lrst_sync <= 2'h0;
    else
      lrst_sync <= {lrst_sync[0], 1'b1};
  end
  assign lrst_n = lrst_sync[1];
  assign link_out = l.pins;

  // Channel engine: every step happens on a link clock edge, so nothing here
  // depends on a minimum bit rate.
  always_comb
  begin
    next_l = l;
    // Configuration is quasi-static and crosses bit by bit through two stages.
    next_l.cfg_meta = h.cfg;
    next_l.cfg = l.cfg_meta;
    next_l.txt_sync = {l.txt_sync[0], h.tx_tgl};
    wbits = spcs_word_bits(l.cfg.wl_code);
    wide = l.cfg.rx_wide_channel_mode & l.cfg.tx_wide_channel_mode;
    if (l.cfg.clock_halt_mode)
      limit = SPCS_LIMIT_HALT;
    else if (wide)
      limit = SPCS_LIMIT_WIDE;
    else
      limit = SPCS_LIMIT_NARROW;
    // A master in clock halt mode opens its own frame once a word is waiting.
    if (l.cfg.clock_halt_mode && l.cfg.spi_master)
      start = l.tx_full & ~l.active;
    else
      start = link_in.frame_sync;
    live = start | l.active;
    cur_chan = start ? 7'h00 : l.chan;
    cur_bit = start ? 5'h00 : l.bit_idx;
    // Partition index is the upper channel bits, enable bit the lower four.
    rx_en = ({1'b0, cur_chan} < limit) && l.cfg.rx_ena[cur_chan[6:4]][cur_chan[3:0]];
    tx_en = ({1'b0, cur_chan} < limit) && l.cfg.tx_ena[cur_chan[6:4]][cur_chan[3:0]];
    last = ({1'b0, cur_bit} == 6'(wbits - 6'h01));
    if ((l.txt_sync[1] != l.tx_seen) && !l.tx_full)
    begin
      next_l.tx_seen = l.txt_sync[1];
      next_l.tx_buf = h.tx_word;
      next_l.tx_full = 1'b1;
    end
    next_l.pins.frame_sync = start & l.cfg.clock_halt_mode & l.cfg.spi_master;
    next_l.pins.frame_sync_oe = l.cfg.clock_halt_mode & l.cfg.spi_master;
    next_l.pins.data_oe = 1'b0;
    if (live)
    begin
      next_l.rx_sh = {l.rx_sh[30:0], link_in.data};
      next_l.pins.data_oe = tx_en;
      if (cur_bit == 5'h00)
      begin
        // Disabled channels send nothing and keep the pending word.
        next_l.tx_sh = (tx_en && l.tx_full) ? (l.tx_buf << (6'h20 - wbits)) : 32'h0000_0000;
        if (tx_en)
          next_l.tx_full = 1'b0;
      end
      next_l.pins.data = next_l.tx_sh[31];
      next_l.tx_sh = next_l.tx_sh << 1;
      if (last)
      begin
        if (rx_en)
        begin
          next_l.rx_hold = next_l.rx_sh & (32'hffff_ffff >> (6'h20 - wbits));
          next_l.rx_chan = cur_chan;
          next_l.rx_tgl = ~l.rx_tgl;
        end
        next_l.bit_idx = 5'h00;
        next_l.chan = 7'(cur_chan + 7'h01);
        next_l.active = 8'({1'b0, cur_chan} + 8'h01) < limit;
      end
      else
      begin
        next_l.bit_idx = 5'(cur_bit + 5'h01);
        next_l.chan = cur_chan;
        next_l.active = 1'b1;
      end
    end
  end

  // Link side state register.
  always_ff @(posedge link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
      l <= '0;
    else
      l <= next_l;
  end

  // ==========================================================================
  // Checks
  sequence s_wr_rx_a;
    hsel && htrans[1] && hready && hwrite && (haddr[7:0] == SPCS_OFS_RX_ENA);
  endsequence

  property p_rx_ena_write;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_rx_a ##1 1'b1 |=> (h.cfg.rx_ena[0] == $past(hwdata[15:0]));
  endproperty
  a_rx_ena_write: assert property (p_rx_ena_write)
    else $error("Receive enable write not stored.");

  property p_rd_one_wait;
    @(posedge hclk) disable iff (!hresetn)
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_one_wait: assert property (p_rd_one_wait)
    else $error("Read did not finish after one wait state.");

  property p_rx_evt_full;
    @(posedge hclk) disable iff (!hresetn)
    rx_evt |=> h.rx_full && (h.rx_chan == $past(l.rx_chan));
  endproperty
  a_rx_evt_full: assert property (p_rx_evt_full)
    else $error("Received word not flagged.");

  property p_rx_only_enabled;
    @(posedge link_clk) disable iff (!lrst_n)
    live && last && !rx_en |=> $stable(l.rx_tgl);
  endproperty
  a_rx_only_enabled: assert property (p_rx_only_enabled)
    else $error("Disabled channel was received.");

  property p_tx_drive;
    @(posedge link_clk) disable iff (!lrst_n)
    live |=> (link_out.data_oe == $past(tx_en));
  endproperty
  a_tx_drive: assert property (p_tx_drive)
    else $error("Transmit enable does not match channel.");

  property p_narrow_end;
    @(posedge link_clk) disable iff (!lrst_n)
    live && last && !wide && !l.cfg.clock_halt_mode && (cur_chan == 7'h1f) |=> !l.active;
  endproperty
  a_narrow_end: assert property (p_narrow_end)
    else $error("Narrow frame ran past channel 31.");

  property p_wide_span;
    @(posedge link_clk) disable iff (!lrst_n)
    live && last && wide && !l.cfg.clock_halt_mode && (cur_chan == 7'h1f) |=> l.active;
  endproperty
  a_wide_span: assert property (p_wide_span)
    else $error("Wide frame stopped at channel 31.");

  property p_halt_one_word;
    @(posedge link_clk) disable iff (!lrst_n)
    live && last && l.cfg.clock_halt_mode |=> !l.active;
  endproperty
  a_halt_one_word: assert property (p_halt_one_word)
    else $error("Clock halt frame held more than one word.");

  property p_bit_range;
    @(posedge link_clk) disable iff (!lrst_n)
    l.active |-> ({1'b0, l.bit_idx} < wbits);
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("Bit index beyond word length.");

  property p_role_shared;
    @(posedge link_clk) disable iff (!lrst_n)
    l.cfg.clock_halt_mode && !l.cfg.spi_master |=> !link_out.frame_sync_oe;
  endproperty
  a_role_shared: assert property (p_role_shared)
    else $error("Slave drives frame sync.");

endmodule

/* File: spcs_partner.sv */
// Far-side serial device model: makes the link clock within frames and in idle ticks between them, and logs sent bits.
`timescale 1ns/1ps
module spcs_partner
  import spcs_pkg::*;
(
  // Link towards the port
  output logic link_clk,
  output spcs_link_in_s link_in,
  input wire spcs_link_out_s link_out
);
  // ==========================================================================
  // Capture of the port's transmit bits
  logic [31:0] cap;
  int cap_n;
  int fs_n;

  // Word carried by channel c; only its low W bits go on the wire.
  function automatic logic [31:0] word(input int c);
    logic [7:0] x;
    x = c[7:0];
    return {24'h6b2d4e, x ^ 8'h96};
  endfunction

  // Bits are taken on the falling edge, 38.7 ns after their launch edge, once the output has settled.
  always @(negedge link_clk)
  begin
    if (link_out.data_oe === 1'b1)
    begin
      cap = {cap[30:0], link_out.data};
      cap_n = cap_n + 1;
    end
    // Start pulses that the port drives as clock halt master.
    if (link_out.frame_sync_oe === 1'b1 && link_out.frame_sync === 1'b1)
      fs_n = fs_n + 1;
  end

  // Idle line levels at time zero.
  initial
  begin
    link_clk = 1'b0;
    link_in = '0;
    cap = '0;
    cap_n = 0;
    fs_n = 0;
  end

  // One 80 ns bit, offset so that its rising edge never meets the bus clock's edges.
  task automatic pulse();
    #41.3 link_clk = 1'b1;
    #38.7 link_clk = 1'b0;
  endtask

  // Edges outside any frame; the data line keeps changing so no stale bit survives.
  task automatic tick(input int n);
    repeat (n)
    begin
      link_in.frame_sync = 1'b0;
      link_in.data = ~link_in.data;
      pulse();
    end
  endtask

  // A frame of n edges of W-bit channels, MSB first; the clock then stops dead.
  task automatic frame(input int w, input int n);
    logic [31:0] v;
    cap = '0;
    cap_n = 0;
    fs_n = 0;
    for (int e = 0; e < n; e++)
    begin
      v = word(e / w);
      link_in.frame_sync = (e == 0);
      link_in.data = v[w - 1 - e % w];
      pulse();
    end
    link_in.frame_sync = 1'b0;
    link_in.data = ~link_in.data;
  endtask
endmodule

/* File: spcs_bench.sv */
// Self-checking bench: register traffic over the bus and link traffic through the partner.
`timescale 1ns/1ps
module spcs_bench;
  import spcs_pkg::*;
  // ==========================================================================
  // Signals
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic link_clk;
  spcs_link_in_s link_in;
  spcs_link_out_s link_out;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int wl[6] = '{8, 12, 16, 20, 24, 32};

  // Bus clock of 5 ns.
  always #2.5 hclk = ~hclk;

  // With one slave its ready output is the bus's ready.
  spcs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
    .link_in(link_in), .link_out(link_out));
  spcs_partner partner (.link_clk(link_clk), .link_in(link_in), .link_out(link_out));

  // ==========================================================================
  // Bus and checking tasks
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, '0);
    chk(nm, exp, q);
  endtask

  // Polls the receive status a bounded number of times for a new word.
  task automatic wait_full();
    int k;
    k = 0;
    do
    begin
      xfer(1'b0, SPCS_OFS_RX_STAT, '0);
      k++;
    end
    while (q[8] !== 1'b1 && k < 40);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // The longest test is the 128-channel frame; the ceiling leaves ample margin.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Tests
  initial
  begin
    // Reset falls from unknown at time zero so that both domains see an edge.
    hresetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= '0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    partner.tick(4);
    for (int i = 0; i < 16; i++)
      rd_chk(SPCS_OFS_RX_ENA + 8'(4 * i), 32'h0, "enable reset");
    rd_chk(SPCS_OFS_CTRL_ONE, 32'h0, "control one reset");
    rd_chk(SPCS_OFS_CTRL_TWO, 32'h0, "control two reset");
    for (int i = 0; i < 16; i++)
      xfer(1'b1, SPCS_OFS_RX_ENA + 8'(4 * i), 32'hffff_0000 | 32'(16'(i * 16'h0f0f) ^ 16'hc35a));
    for (int i = 0; i < 16; i++)
      rd_chk(SPCS_OFS_RX_ENA + 8'(4 * i), 32'(16'(i * 16'h0f0f) ^ 16'hc35a), "enable");
    xfer(1'b1, SPCS_OFS_CTRL_ONE, 32'h200);
    rd_chk(SPCS_OFS_CTRL_ONE, 32'h200, "control one wide");
    rd_chk(8'hfc, 32'h0, "unmapped");
    chk("response", 32'h0, {31'h0, hresp});
    for (int i = 0; i < 17; i++)
      xfer(1'b1, SPCS_OFS_RX_ENA + 8'(4 * i), 32'h0);
    $display("Test registers done");
    // Narrow frame: only channel 19 (partition B bit 3) is received.
    xfer(1'b1, SPCS_OFS_CONFIG, 32'h0);
    xfer(1'b1, SPCS_OFS_RX_ENA + 8'h04, 32'h8);
    partner.tick(4);
    partner.frame(8, 256);
    wait_full();
    chk("rx status narrow", 32'h113, q);
    rd_chk(SPCS_OFS_RX_DATA, partner.word(19) & 32'hff, "rx word narrow");
    // One wide bit alone keeps the narrow frame, so channel 32 is never served.
    xfer(1'b1, SPCS_OFS_CTRL_ONE, 32'h200);
    xfer(1'b1, SPCS_OFS_RX_ENA + 8'h04, 32'h0);
    xfer(1'b1, SPCS_OFS_RX_ENA + 8'h08, 32'h1);
    partner.tick(4);
    partner.frame(8, 320);
    repeat (40) @(posedge hclk);
    xfer(1'b0, SPCS_OFS_RX_STAT, '0);
    chk("rx full one wide bit", 32'h0, q & 32'h100);
    $display("Test narrow receive done");
    // Wide frame: channels 32 and 127 arrive, the second overruns the first.
    xfer(1'b1, SPCS_OFS_CTRL_TWO, 32'h200);
    xfer(1'b1, SPCS_OFS_RX_ENA + 8'h1c, 32'h8000);
    partner.tick(4);
    partner.frame(8, 1024);
    wait_full();
    chk("rx status wide", 32'h37f, q);
    rd_chk(SPCS_OFS_RX_DATA, partner.word(127) & 32'hff, "rx word wide");
    xfer(1'b1, SPCS_OFS_RX_STAT, 32'h200);
    rd_chk(SPCS_OFS_RX_STAT, 32'h7f, "overrun clear");
    xfer(1'b1, SPCS_OFS_CTRL_ONE, 32'h0);
    xfer(1'b1, SPCS_OFS_CTRL_TWO, 32'h0);
    xfer(1'b1, SPCS_OFS_RX_ENA + 8'h08, 32'h0);
    xfer(1'b1, SPCS_OFS_RX_ENA + 8'h1c, 32'h0);
    $display("Test wide receive done");
    // Transmit channel 0 at every word length; no other channel may drive.
    xfer(1'b1, SPCS_OFS_TX_ENA, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      xfer(1'b1, SPCS_OFS_CONFIG, 32'(k));
      xfer(1'b1, SPCS_OFS_TX_DATA, 32'hc3a5_96e7);
      partner.tick(4);
      partner.frame(wl[k], 2 * wl[k]);
      chk("tx bit count", 32'(wl[k]), 32'(partner.cap_n));
      chk("tx word", 32'hc3a5_96e7 & (32'hffff_ffff >> (32 - wl[k])), partner.cap);
    end
    $display("Test transmit done");
    // Clock halt: the frame line is driven only in the master role.
    xfer(1'b1, SPCS_OFS_CONFIG, 32'h18);
    partner.tick(4);
    chk("frame drive master", 32'h1, {31'h0, link_out.frame_sync_oe});
    xfer(1'b1, SPCS_OFS_CONFIG, 32'h08);
    partner.tick(4);
    chk("frame drive slave", 32'h0, {31'h0, link_out.frame_sync_oe});
    // As master a pending word opens a one-word frame with a single start pulse.
    xfer(1'b1, SPCS_OFS_CONFIG, 32'h18);
    partner.tick(4);
    xfer(1'b1, SPCS_OFS_TX_DATA, 32'h0000_00a5);
    partner.frame(8, 16);
    chk("halt start pulses", 32'h1, 32'(partner.fs_n));
    chk("halt bit count", 32'h8, 32'(partner.cap_n));
    chk("halt word", 32'ha5, partner.cap);
    $display("Test clock halt done");
    end_of_test();
  end
endmodule
